// ---- rtl/rpf_config_bank.sv ----
// Record-path input and DSP filter configuration bank behind APB.
// Assumes APB master on clk_sys_in; line PGA codes arrive from a neighbour bank.
`timescale 1ns/100ps
`default_nettype none
module rpf_config_bank
  import rpf_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [2:0] line_a_pga_gain_in,
  input wire logic [2:0] line_b_pga_gain_in,
  output rpf_route_t route_out,
  output rpf_dsp_t dsp_out,
  output logic signed [5:0] line_a_gain_db_out,
  output logic signed [5:0] line_b_gain_db_out
);
  logic [7:0] input_mode_ff;
  logic [7:0] left_mix_ff;
  logic [7:0] right_mix_ff;
  logic [7:0] filter_ff;
  logic [7:0] adc_ctrl_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic access_ok;
  logic wr_en;
  logic addr_hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] nxt_adc_ctrl;
  logic [7:0] status_val;
  logic [7:0] nxt_rdata;
  rpf_mic_mux_t mic_mux;
  logic [1:0] mic1_pair;
  logic [1:0] mic2_pair;

  // Single-cycle access phase: every transfer completes without wait states
  assign pready_out = 1'b1;
  assign prdata_out = prdata_ff;
  assign pslverr_out = pslverr_ff;
  assign access_ok = psel_in && penable_in;
  assign idx = paddr_in[9:2];
  assign wbyte = pwdata_in[7:0];
  assign addr_hit = (paddr_in[31:10] == 22'h00_0000) && (paddr_in[1:0] == 2'h0) &&
                    ((idx == RPF_IDX_INPUT_MODE) || (idx == RPF_IDX_LEFT_MIX) ||
                     (idx == RPF_IDX_RIGHT_MIX) || (idx == RPF_IDX_FILTER) ||
                     (idx == RPF_IDX_ADC_CTRL) || (idx == RPF_IDX_STATUS));
  // Only lane 0 carries data; a write without it stores nothing
  assign wr_en = access_ok && pwrite_in && addr_hit && pstrb_in[0];

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      input_mode_ff <= RPF_RST_INPUT_MODE;
    end else if (wr_en && idx == RPF_IDX_INPUT_MODE) begin
      input_mode_ff <= wbyte & RPF_MASK_INPUT_MODE;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      left_mix_ff <= RPF_RST_MIX;
    end else if (wr_en && idx == RPF_IDX_LEFT_MIX) begin
      left_mix_ff <= wbyte & RPF_MASK_MIX;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      right_mix_ff <= RPF_RST_MIX;
    end else if (wr_en && idx == RPF_IDX_RIGHT_MIX) begin
      right_mix_ff <= wbyte & RPF_MASK_MIX;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      filter_ff <= RPF_RST_FILTER;
    end else if (wr_en && idx == RPF_IDX_FILTER) begin
      filter_ff <= wbyte & RPF_MASK_FILTER;
    end
  end

  // Voice filters pin the ratio at 128; a write cannot clear it
  always_comb begin
    nxt_adc_ctrl = adc_ctrl_ff;
    if (wr_en && idx == RPF_IDX_ADC_CTRL) begin
      nxt_adc_ctrl = wbyte & RPF_MASK_ADC_CTRL;
    end
    if (!filter_ff[RPF_BIT_MUSIC_MODE] ||
        (wr_en && idx == RPF_IDX_FILTER && !wbyte[RPF_BIT_MUSIC_MODE])) begin
      nxt_adc_ctrl[RPF_BIT_OSR128] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      adc_ctrl_ff <= RPF_RST_ADC_CTRL;
    end else begin
      adc_ctrl_ff <= nxt_adc_ctrl;
    end
  end

  // Status: flags combinations that software is expected to avoid; bit 0 mirrors the OSR 128 setting
  assign status_val = {4'h0,
                       (filter_ff[RPF_BIT_HIGH_RATE] && adc_ctrl_ff[RPF_BIT_OSR128]),
                       (filter_ff[RPF_BIT_HIGH_RATE] && !filter_ff[RPF_BIT_MUSIC_MODE]),
                       (input_mode_ff[1:0] == RPF_MIC_RESERVED),
                       adc_ctrl_ff[RPF_BIT_OSR128]};

  always_comb begin
    nxt_rdata = 8'h00;
    case (idx)
      RPF_IDX_INPUT_MODE: nxt_rdata = input_mode_ff;
      RPF_IDX_LEFT_MIX: nxt_rdata = left_mix_ff;
      RPF_IDX_RIGHT_MIX: nxt_rdata = right_mix_ff;
      RPF_IDX_FILTER: nxt_rdata = filter_ff;
      RPF_IDX_ADC_CTRL: nxt_rdata = adc_ctrl_ff;
      RPF_IDX_STATUS: nxt_rdata = status_val;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data registered in setup so it is stable through the access phase
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_ff <= {24'h00_0000, addr_hit ? nxt_rdata : 8'h00};
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pslverr_ff <= 1'b0;
    end else if (psel_in && !penable_in) begin
      pslverr_ff <= !addr_hit;
    end
  end

  // Microphone pair mux: pair codes 1, 2, 3
  assign mic_mux = rpf_mic_mux_t'(input_mode_ff[RPF_POS_MIC_MUX +: 2]);
  // Local pair values keep the struct out of a second process's reach
  always_comb begin
    mic1_pair = 2'h1;
    mic2_pair = 2'h2;
    case (mic_mux)
      RPF_MIC_DEFAULT: begin
        mic1_pair = 2'h1;
        mic2_pair = 2'h2;
      end
      RPF_MIC_PAIR3_TO_MIC1: begin
        mic1_pair = 2'h3;
        mic2_pair = 2'h2;
      end
      RPF_MIC_PAIR3_TO_MIC2: begin
        mic1_pair = 2'h1;
        mic2_pair = 2'h3;
      end
      default: begin
        // Reserved code keeps the default routing
        mic1_pair = 2'h1;
        mic2_pair = 2'h2;
      end
    endcase
  end
  assign route_out.mic1_pair = mic1_pair;
  assign route_out.mic2_pair = mic2_pair;

  assign route_out.line_a_ext_gain_sel = input_mode_ff[RPF_BIT_LINE_A_EXT];
  assign route_out.line_b_ext_gain_sel = input_mode_ff[RPF_BIT_LINE_B_EXT];
  assign route_out.left_adc_source_sel = left_mix_ff[6:0];
  assign route_out.right_adc_source_sel = right_mix_ff[6:0];
  assign route_out.gain_stages_bypass = adc_ctrl_ff[RPF_BIT_DIRECT_FS];
  assign route_out.analog_out_route_en = !adc_ctrl_ff[RPF_BIT_DIRECT_FS];
  assign route_out.adc_left_en = adc_ctrl_ff[RPF_BIT_ADC_L_EN];
  assign route_out.adc_right_en = adc_ctrl_ff[RPF_BIT_ADC_R_EN];

  assign dsp_out.music_filter_sel = filter_ff[RPF_BIT_MUSIC_MODE];
  assign dsp_out.record_dc_block_en = filter_ff[RPF_BIT_REC_DCB];
  assign dsp_out.playback_dc_block_en = filter_ff[RPF_BIT_PLAY_DCB];
  assign dsp_out.high_rate_mode = filter_ff[RPF_BIT_HIGH_RATE];
  // Only meaningful with the FIR filters; voice mode keeps 8x
  assign dsp_out.interp_4x = filter_ff[RPF_BIT_HIGH_RATE] &&
                             filter_ff[RPF_BIT_MUSIC_MODE];
  assign dsp_out.adc_osr_128 = adc_ctrl_ff[RPF_BIT_OSR128];
  assign dsp_out.rec_src_dmic_l = adc_ctrl_ff[RPF_BIT_USE_DMIC_L];
  assign dsp_out.rec_src_dmic_r = adc_ctrl_ff[RPF_BIT_USE_DMIC_R];

  rpf_pga_decode u_pga_a (
    .code_in(line_a_pga_gain_in),
    .gain_db_out(line_a_gain_db_out)
  );

  rpf_pga_decode u_pga_b (
    .code_in(line_b_pga_gain_in),
    .gain_db_out(line_b_gain_db_out)
  );

  // Checks
  sequence s_filter_voice_write;
    wr_en && idx == RPF_IDX_FILTER && !wbyte[RPF_BIT_MUSIC_MODE];
  endsequence

  a_voice_forces_osr: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_filter_voice_write |=> dsp_out.adc_osr_128 && !dsp_out.music_filter_sel)
    else $error("voice filter did not force osr 128");

  a_voice_osr_held: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !filter_ff[RPF_BIT_MUSIC_MODE] |-> adc_ctrl_ff[RPF_BIT_OSR128])
    else $error("osr 128 lost while voice filters selected");

  a_osr_music_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_en && idx == RPF_IDX_ADC_CTRL && filter_ff[RPF_BIT_MUSIC_MODE]) |=>
      dsp_out.adc_osr_128 == $past(wbyte[RPF_BIT_OSR128]))
    else $error("osr write in music mode not taken");

  a_ext_gain_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_en && idx == RPF_IDX_INPUT_MODE) |=>
      route_out.line_a_ext_gain_sel == $past(wbyte[7]) &&
      route_out.line_b_ext_gain_sel == $past(wbyte[6]))
    else $error("external gain select mismatch");

  a_mic_pair_route: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (input_mode_ff[1:0] == 2'h1) |-> route_out.mic1_pair == 2'h3 && route_out.mic2_pair == 2'h2)
    else $error("mic pair three not routed to mic 1");

  a_left_mix_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_en && idx == RPF_IDX_LEFT_MIX) |=> route_out.left_adc_source_sel == $past(wbyte[6:0]))
    else $error("left mixer select mismatch");

  a_right_mix_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !(wr_en && idx == RPF_IDX_RIGHT_MIX) |=> $stable(route_out.right_adc_source_sel))
    else $error("right mixer changed without write");

  a_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    filter_ff[3:0] == 4'h0 && left_mix_ff[7] == 1'b0 && input_mode_ff[5:2] == 4'h0)
    else $error("reserved bits not zero");

  a_interp_fir_only: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    dsp_out.interp_4x |-> dsp_out.music_filter_sel && dsp_out.high_rate_mode)
    else $error("4x interpolation outside FIR high rate");

  a_direct_no_output: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    adc_ctrl_ff[RPF_BIT_DIRECT_FS] |->
      route_out.gain_stages_bypass && !route_out.analog_out_route_en)
    else $error("direct mode still routes to output mixers");

  a_dcb_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_en && idx == RPF_IDX_FILTER) |=>
      dsp_out.record_dc_block_en == $past(wbyte[6]) &&
      dsp_out.playback_dc_block_en == $past(wbyte[5]))
    else $error("dc blocking enables mismatch");

  // Register write effects and FIR high-rate interpolation
  sequence s_adc_ctrl_write;
    wr_en && idx == RPF_IDX_ADC_CTRL;
  endsequence

  sequence s_setup_phase;
    psel_in && !penable_in;
  endsequence

  a_voice_osr_locked: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (s_adc_ctrl_write ##0 !filter_ff[RPF_BIT_MUSIC_MODE]) |=> dsp_out.adc_osr_128)
    else $error("osr write taken under voice filters");

  a_adc_en_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_adc_ctrl_write |=>
      route_out.adc_left_en == $past(wbyte[RPF_BIT_ADC_L_EN]) &&
      route_out.adc_right_en == $past(wbyte[RPF_BIT_ADC_R_EN]))
    else $error("adc enable mismatch");

  a_dmic_src_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_adc_ctrl_write |=>
      dsp_out.rec_src_dmic_l == $past(wbyte[RPF_BIT_USE_DMIC_L]) &&
      dsp_out.rec_src_dmic_r == $past(wbyte[RPF_BIT_USE_DMIC_R]))
    else $error("record source select mismatch");

  a_direct_mode_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_adc_ctrl_write |=> route_out.gain_stages_bypass == $past(wbyte[RPF_BIT_DIRECT_FS]))
    else $error("direct mode select mismatch");

  a_right_mix_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_en && idx == RPF_IDX_RIGHT_MIX) |=>
      route_out.right_adc_source_sel == $past(wbyte[6:0]))
    else $error("right mixer select mismatch");

  a_mode_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_en && idx == RPF_IDX_FILTER) |=>
      dsp_out.music_filter_sel == $past(wbyte[RPF_BIT_MUSIC_MODE]) &&
      dsp_out.high_rate_mode == $past(wbyte[RPF_BIT_HIGH_RATE]))
    else $error("filter mode mismatch");

  a_interp_high_rate: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    dsp_out.high_rate_mode && dsp_out.music_filter_sel |-> dsp_out.interp_4x)
    else $error("4x interpolation missing in FIR high rate");

  // Microphone pair routing
  a_mic_pair3_mic2: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (mic_mux == RPF_MIC_PAIR3_TO_MIC2) |->
      route_out.mic1_pair == 2'h1 && route_out.mic2_pair == 2'h3)
    else $error("mic pair three not routed to mic 2");

  a_mic_default_route: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (mic_mux == RPF_MIC_DEFAULT || mic_mux == RPF_MIC_RESERVED) |->
      route_out.mic1_pair == 2'h1 && route_out.mic2_pair == 2'h2)
    else $error("default mic routing lost");

  // Bus answer and reserved data
  a_unmapped_slverr: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (s_setup_phase ##0 !addr_hit) |=>
      pslverr_out && ($past(pwrite_in) || prdata_out == 32'h0000_0000))
    else $error("unmapped access not refused");

  a_rdata_upper_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    prdata_out[31:8] == 24'h00_0000)
    else $error("read data above byte lane not zero");

  // Line gain decode at both ends of the code range
  a_pga_top_gain: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (line_a_pga_gain_in == RPF_PGA_20DB) |-> line_a_gain_db_out == 6'sd20)
    else $error("line A top gain code mismatch");

  a_pga_floor_gain: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (line_b_pga_gain_in > RPF_PGA_M3DB) |-> line_b_gain_db_out == -6'sd6)
    else $error("line B floor gain code mismatch");
endmodule
`default_nettype wire

// ---- rtl/rpf_pkg.sv ----
// Package for the record-path input and filter configuration bank.
// Assumes a 32-bit APB slave; registers occupy aligned words.
package rpf_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] RPF_IDX_INPUT_MODE = 8'h0f;
  localparam logic [7:0] RPF_IDX_LEFT_MIX = 8'h15;
  localparam logic [7:0] RPF_IDX_RIGHT_MIX = 8'h16;
  localparam logic [7:0] RPF_IDX_FILTER = 8'h26;
  localparam logic [7:0] RPF_IDX_ADC_CTRL = 8'h30;
  localparam logic [7:0] RPF_IDX_STATUS = 8'h31;

  // Input mode register fields
  localparam int RPF_BIT_LINE_A_EXT = 7;
  localparam int RPF_BIT_LINE_B_EXT = 6;
  localparam int RPF_POS_MIC_MUX = 0;
  localparam logic [7:0] RPF_MASK_INPUT_MODE = 8'hc3;
  localparam logic [7:0] RPF_RST_INPUT_MODE = 8'h00;

  // Mixer select fields
  localparam logic [7:0] RPF_MASK_MIX = 8'h7f;
  localparam logic [7:0] RPF_RST_MIX = 8'h00;

  // Filter register fields
  localparam int RPF_BIT_MUSIC_MODE = 7;
  localparam int RPF_BIT_REC_DCB = 6;
  localparam int RPF_BIT_PLAY_DCB = 5;
  localparam int RPF_BIT_HIGH_RATE = 4;
  localparam logic [7:0] RPF_MASK_FILTER = 8'hf0;
  localparam logic [7:0] RPF_RST_FILTER = 8'h80;

  // ADC control fields (own register)
  localparam int RPF_BIT_ADC_L_EN = 0;
  localparam int RPF_BIT_ADC_R_EN = 1;
  localparam int RPF_BIT_OSR128 = 2;
  localparam int RPF_BIT_DIRECT_FS = 3;
  localparam int RPF_BIT_USE_DMIC_L = 4;
  localparam int RPF_BIT_USE_DMIC_R = 5;
  localparam logic [7:0] RPF_MASK_ADC_CTRL = 8'h3f;
  localparam logic [7:0] RPF_RST_ADC_CTRL = 8'h00;

  // Line PGA gain codes and results in dB
  localparam logic [2:0] RPF_PGA_20DB = 3'h0;
  localparam logic [2:0] RPF_PGA_14DB = 3'h1;
  localparam logic [2:0] RPF_PGA_3DB = 3'h2;
  localparam logic [2:0] RPF_PGA_0DB = 3'h3;
  localparam logic [2:0] RPF_PGA_M3DB = 3'h4;

  typedef enum logic [1:0] {
    RPF_MIC_DEFAULT = 2'h0,
    RPF_MIC_PAIR3_TO_MIC1 = 2'h1,
    RPF_MIC_PAIR3_TO_MIC2 = 2'h2,
    RPF_MIC_RESERVED = 2'h3
  } rpf_mic_mux_t;

  // Routing of the analog front end, one bundle
  typedef struct packed {
    logic line_a_ext_gain_sel;
    logic line_b_ext_gain_sel;
    logic [1:0] mic1_pair;
    logic [1:0] mic2_pair;
    logic [6:0] left_adc_source_sel;
    logic [6:0] right_adc_source_sel;
    logic gain_stages_bypass;
    logic analog_out_route_en;
    logic adc_left_en;
    logic adc_right_en;
  } rpf_route_t;

  // DSP filter controls, one bundle
  typedef struct packed {
    logic music_filter_sel;
    logic record_dc_block_en;
    logic playback_dc_block_en;
    logic high_rate_mode;
    logic interp_4x;
    logic adc_osr_128;
    logic rec_src_dmic_l;
    logic rec_src_dmic_r;
  } rpf_dsp_t;
endpackage

// ---- rtl/rpf_pga_decode.sv ----
// Line input PGA gain decoder: code to signed gain in dB.
// Assumes a static gain code from the register file.
`timescale 1ns/100ps
`default_nettype none
module rpf_pga_decode
  import rpf_pkg::*;
(
  input wire logic [2:0] code_in,
  output logic signed [5:0] gain_db_out
);
  always_comb begin
    case (code_in)
      RPF_PGA_20DB: gain_db_out = 6'sd20;
      RPF_PGA_14DB: gain_db_out = 6'sd14;
      RPF_PGA_3DB: gain_db_out = 6'sd3;
      RPF_PGA_0DB: gain_db_out = 6'sd0;
      RPF_PGA_M3DB: gain_db_out = -6'sd3;
      default: gain_db_out = -6'sd6;
    endcase
  end
endmodule
`default_nettype wire

// ---- bench/rpf_apb_host.sv ----
// Host model: an APB master that software uses to reach the bank.
// Assumes one clock; the slave may stretch the access with pready.
`timescale 1ns/100ps
`default_nettype none
module rpf_apb_host (
  input wire logic clk_sys_in,
  input wire logic pready_in,
  input wire logic [31:0] prdata_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [31:0] paddr_out,
  output logic [31:0] pwdata_out,
  output logic [3:0] pstrb_out
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 32'h0000_0000;
    pwdata_out = 32'h0000_0000;
    pstrb_out = 4'h0;
  end

  // Request stays put until pready is seen high; bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_sys_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= addr;
    pwdata_out <= data;
    pstrb_out <= 4'h1;
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_in !== 1'b1) begin
      @(posedge clk_sys_in);
    end
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_record_path_input_filter_config.sv ----
// Self-checking bench for the record-path configuration bank.
// Assumes the host model drives APB; PGA codes come from the bench.
`timescale 1ns/100ps
`default_nettype none
module tb_record_path_input_filter_config;
  import rpf_pkg::*;
  logic clk_sys_in, sys_rst_in, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] pga_a, pga_b;
  logic signed [5:0] db_a, db_b;
  rpf_route_t route;
  rpf_dsp_t dsp;
  int error_cnt, compares;

  always #2 clk_sys_in = ~clk_sys_in;

  rpf_apb_host i_host (.clk_sys_in(clk_sys_in), .pready_in(pready), .prdata_in(prdata),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));

  rpf_config_bank i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .line_a_pga_gain_in(pga_a), .line_b_pga_gain_in(pga_b), .route_out(route),
    .dsp_out(dsp), .line_a_gain_db_out(db_a), .line_b_gain_db_out(db_b));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] ba(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  // Settle time after the write edge so outputs are looked at once updated
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    i_host.xfer(1'b1, ba(idx), {24'h00_0000, v}, rd, err);
    #1;
    chk("wr_err", 32'(err), 32'h0);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    i_host.xfer(1'b0, ba(idx), 32'h0000_0000, rd, err);
    chk(name, rd, {24'h00_0000, exp});
    chk("rd_err", 32'(err), 32'h0);
  endtask

  task automatic test_reset();
    rd_chk("input_mode", RPF_IDX_INPUT_MODE, 8'h00);
    rd_chk("left_mix", RPF_IDX_LEFT_MIX, 8'h00);
    rd_chk("right_mix", RPF_IDX_RIGHT_MIX, 8'h00);
    rd_chk("filter", RPF_IDX_FILTER, 8'h80);
    rd_chk("adc_ctrl", RPF_IDX_ADC_CTRL, 8'h00);
    rd_chk("status", RPF_IDX_STATUS, 8'h00);
    chk("music_sel", 32'(dsp.music_filter_sel), 32'h1);
    $display("test_reset done");
  endtask

  task automatic test_input_mode();
    logic [1:0] e1 [4];
    logic [1:0] e2 [4];
    e1 = '{2'h1, 2'h3, 2'h1, 2'h1};
    e2 = '{2'h2, 2'h2, 2'h3, 2'h2};
    wr(RPF_IDX_INPUT_MODE, 8'hff);
    rd_chk("input_mode", RPF_IDX_INPUT_MODE, 8'hc3);
    wr(RPF_IDX_INPUT_MODE, 8'h80);
    chk("ext_a", 32'({route.line_a_ext_gain_sel, route.line_b_ext_gain_sel}), 32'h2);
    wr(RPF_IDX_INPUT_MODE, 8'h40);
    chk("ext_b", 32'({route.line_a_ext_gain_sel, route.line_b_ext_gain_sel}), 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(RPF_IDX_INPUT_MODE, 8'(m));
      chk("mic1_pair", 32'(route.mic1_pair), 32'(e1[m]));
      chk("mic2_pair", 32'(route.mic2_pair), 32'(e2[m]));
    end
    $display("test_input_mode done");
  endtask

  task automatic test_mixers();
    for (int i = 0; i < 7; i++) begin
      wr(RPF_IDX_LEFT_MIX, 8'(1 << i));
      wr(RPF_IDX_RIGHT_MIX, 8'(8'h40 >> i));
      chk("left_src", 32'(route.left_adc_source_sel), 32'(1 << i));
      chk("right_src", 32'(route.right_adc_source_sel), 32'(8'h40 >> i));
    end
    wr(RPF_IDX_LEFT_MIX, 8'hff);
    wr(RPF_IDX_RIGHT_MIX, 8'hff);
    rd_chk("left_mix", RPF_IDX_LEFT_MIX, 8'h7f);
    rd_chk("right_mix", RPF_IDX_RIGHT_MIX, 8'h7f);
    $display("test_mixers done");
  endtask

  task automatic test_filter_osr();
    wr(RPF_IDX_FILTER, 8'hff);
    rd_chk("filter", RPF_IDX_FILTER, 8'hf0);
    chk("dsp_bits", 32'(dsp[7:3]), 32'h1f);
    wr(RPF_IDX_ADC_CTRL, 8'h00);
    chk("osr_64", 32'(dsp.adc_osr_128), 32'h0);
    rd_chk("status_hr", RPF_IDX_STATUS, 8'h02);
    // High rate off first so the 128x pick stays legal
    wr(RPF_IDX_FILTER, 8'hc0);
    chk("interp_8x", 32'(dsp.interp_4x), 32'h0);
    wr(RPF_IDX_ADC_CTRL, 8'h04);
    chk("osr_128", 32'(dsp.adc_osr_128), 32'h1);
    wr(RPF_IDX_FILTER, 8'h40);
    chk("voice_dcb", 32'(dsp[7:5]), 32'h2);
    wr(RPF_IDX_ADC_CTRL, 8'h00);
    rd_chk("osr_locked", RPF_IDX_ADC_CTRL, 8'h04);
    chk("osr_forced", 32'(dsp.adc_osr_128), 32'h1);
    wr(RPF_IDX_FILTER, 8'h80);
    wr(RPF_IDX_ADC_CTRL, 8'h00);
    chk("osr_music", 32'(dsp.adc_osr_128), 32'h0);
    $display("test_filter_osr done");
  endtask

  task automatic test_adc_ctrl();
    logic [7:0] v [6];
    v = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h10, 8'h20};
    for (int i = 0; i < 6; i++) begin
      wr(RPF_IDX_ADC_CTRL, v[i]);
      chk("adc_en", 32'({route.adc_left_en, route.adc_right_en}), 32'({v[i][0], v[i][1]}));
      chk("bypass", 32'({route.gain_stages_bypass, route.analog_out_route_en}),
          32'({v[i][3], ~v[i][3]}));
      chk("dmic", 32'({dsp.rec_src_dmic_l, dsp.rec_src_dmic_r}), 32'({v[i][4], v[i][5]}));
    end
    $display("test_adc_ctrl done");
  endtask

  task automatic test_unmapped();
    // Upper address bit set over the filter index: must not alias
    i_host.xfer(1'b1, 32'h0000_0498, 32'h0000_00ff, rd, err);
    chk("wr_slverr", 32'(err), 32'h1);
    i_host.xfer(1'b0, 32'h0000_0040, 32'h0000_0000, rd, err);
    chk("rd_slverr", 32'(err), 32'h1);
    chk("rd_data", rd, 32'h0000_0000);
    rd_chk("filter_kept", RPF_IDX_FILTER, 8'h80);
    $display("test_unmapped done");
  endtask

  task automatic test_pga();
    logic signed [5:0] g [8];
    g = '{6'sd20, 6'sd14, 6'sd3, 6'sd0, -6'sd3, -6'sd6, -6'sd6, -6'sd6};
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys_in);
      pga_a <= 3'(c);
      pga_b <= 3'(7 - c);
      @(posedge clk_sys_in);
      #1;
      chk("gain_a", 32'(db_a), 32'(g[c]));
      chk("gain_b", 32'(db_b), 32'(g[7 - c]));
    end
    $display("test_pga done");
  endtask

  task automatic test_mid_reset();
    wr(RPF_IDX_RIGHT_MIX, 8'h55);
    wr(RPF_IDX_FILTER, 8'h40);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd_chk("right_mix_rst", RPF_IDX_RIGHT_MIX, 8'h00);
    rd_chk("filter_rst", RPF_IDX_FILTER, 8'h80);
    rd_chk("adc_rst", RPF_IDX_ADC_CTRL, 8'h00);
    $display("test_mid_reset done");
  endtask

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_sys_in = 1'b0;
    sys_rst_in = 1'b1;
    pga_a = 3'h0;
    pga_b = 3'h0;
    error_cnt = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    test_reset();
    test_input_mode();
    test_mixers();
    test_filter_osr();
    test_adc_ctrl();
    test_unmapped();
    test_pga();
    test_mid_reset();
    complete_run();
  end

  // Whole run is under two hundred cycles; this is generous
  initial begin
    #40000;
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
